// ===== hw/cspmc_top.sv
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module cspmc_top #(
	parameter logic [15:0] RST_CYC_XTAL = cspmc_pkg::RST_CYC_XTAL,
	parameter logic [15:0] RST_CYC_RC   = cspmc_pkg::RST_CYC_RC
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [2:0]            clock_option,
	input  wire logic [7:0]            first_wake_port,
	input  wire logic [7:0]            second_wake_port,
	input  wire logic                  wake_timer_overflow,
	input  wire logic                  rtc_crystal_tick,
	output cspmc_pkg::cspmc_osc_t      osc_ctrl,
	output logic                       core_reset_hold,
	output logic                       rtc_half_second
);

	// ==========================================================
	// State
	typedef struct packed {
		cspmc_pkg::cspmc_state_t st;
		cspmc_pkg::cspmc_opt_t   opt;
		logic                    high_osc_stop;
		logic                    low_clock_select;
		logic                    sleep_request;
		logic                    green_request;
		logic [7:0]              second_port_wake_enable;
		logic                    wdt_en;
		logic                    cfg_455k;
		logic [7:0]              p0_snap;
		logic [7:0]              p1_snap;
		logic                    rtc_prev;
		logic [13:0]             rtc_cnt;
		logic                    rtc_pulse;
		cspmc_pkg::cspmc_osc_t   osc;
		logic                    rst_hold;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
	} cspmc_top_st_t;

	cspmc_top_st_t s_reg;
	cspmc_top_st_t s_next;

	logic [16:0]            pin_sync;
	logic [7:0]             p0_s;
	logic [7:0]             p1_s;
	logic                   rtc_s;
	logic                   tmr_start;
	logic [15:0]            tmr_load;
	logic                   tmr_done;
	logic                   p0_chg;
	logic                   p1_chg;
	logic                   port_wake;
	logic                   access;
	logic [2:0]             sel;

	// ==========================================================
	// Pin synchronizers and delay timer
	cspmc_sync #(
		.W (17)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       ({rtc_crystal_tick, second_wake_port, first_wake_port}),
		.q       (pin_sync)
	);

	cspmc_delay #(
		.W (cspmc_pkg::TMR_W)
	) u_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.start   (tmr_start),
		.load    (tmr_load),
		.done    (tmr_done)
	);

	assign p0_s      = pin_sync[7:0];
	assign p1_s      = pin_sync[15:8];
	assign rtc_s     = pin_sync[16];
	assign p0_chg    = |(p0_s ^ s_reg.p0_snap);
	assign p1_chg    = |((p1_s ^ s_reg.p1_snap) & s_reg.second_port_wake_enable);
	assign port_wake = p0_chg | p1_chg;
	assign access    = psel & penable;

	// ==========================================================
	// Functions
	// Register select: 0 none, 1 mode, 2 wake enable, 3 config, 4 status
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		logic [2:0] r;
		r = 3'h0;
		case (a)
			cspmc_pkg::OSC_MODE_ADDR: r = 3'h1;
			cspmc_pkg::WAKE_EN_ADDR:  r = 3'h2;
			cspmc_pkg::CFG_ADDR:      r = 3'h3;
			cspmc_pkg::STATUS_ADDR:   r = 3'h4;
			default:                  r = 3'h0;
		endcase
		return r;
	endfunction

	function automatic logic is_fast_rc(input cspmc_pkg::cspmc_opt_t o);
		return (o == cspmc_pkg::OPT_FAST_RC) || (o == cspmc_pkg::OPT_FAST_RC_RTC);
	endfunction

	function automatic logic is_crystal(input cspmc_pkg::cspmc_opt_t o);
		return (o == cspmc_pkg::OPT_XTAL_32K) || (o == cspmc_pkg::OPT_XTAL_4M)
			|| (o == cspmc_pkg::OPT_XTAL_8M);
	endfunction

	// Oscillator enables and pin use from mode and option
	function automatic cspmc_pkg::cspmc_osc_t osc_of(input cspmc_top_st_t s);
		cspmc_pkg::cspmc_osc_t o;
		logic                  hi_on;
		logic                  sleeping;
		o        = '0;
		sleeping = (s.st == cspmc_pkg::ST_SLEEP);
		hi_on    = !sleeping && !s.high_osc_stop;
		o.fast_rc_en   = hi_on && is_fast_rc(s.opt);
		o.ext_osc_en   = hi_on && !is_fast_rc(s.opt);
		o.rtc_xtal_en  = hi_on && (s.opt == cspmc_pkg::OPT_FAST_RC_RTC);
		o.slow_rc_en   = !sleeping
			&& !((s.st == cspmc_pkg::ST_GREEN) && s.cfg_455k && !s.wdt_en);
		o.osc_in_gpio  = (s.opt == cspmc_pkg::OPT_FAST_RC);
		o.osc_out_gpio = (s.opt == cspmc_pkg::OPT_FAST_RC)
			|| (s.opt == cspmc_pkg::OPT_EXT_RC);
		o.sys_clk_slow = (s.st == cspmc_pkg::ST_SLOW)
			|| ((s.st == cspmc_pkg::ST_GREEN) && s.low_clock_select);
		o.cpu_run      = (s.st == cspmc_pkg::ST_NORMAL) || (s.st == cspmc_pkg::ST_SLOW);
		return o;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		s_next    = s_reg;
		tmr_start = 1'b0;
		tmr_load  = cspmc_pkg::WARMUP_CYC;
		sel       = reg_sel(paddr);

		s_next.rtc_pulse = 1'b0;
		s_next.rtc_prev  = rtc_s;

		// Snapshots track the ports while running so a wake compares with entry levels
		if (s_reg.st != cspmc_pkg::ST_SLEEP && s_reg.st != cspmc_pkg::ST_GREEN) begin
			s_next.p0_snap = p0_s;
			s_next.p1_snap = p1_s;
		end

		case (s_reg.st)
			cspmc_pkg::ST_RST_LATCH: begin
				s_next.opt = cspmc_pkg::cspmc_opt_t'(clock_option);
				tmr_start  = 1'b1;
				if (is_crystal(cspmc_pkg::cspmc_opt_t'(clock_option))) begin
					tmr_load = RST_CYC_XTAL;
				end else begin
					tmr_load = RST_CYC_RC;
				end
				s_next.st = cspmc_pkg::ST_RST_WAIT;
			end
			cspmc_pkg::ST_RST_WAIT: begin
				if (tmr_done) begin
					s_next.st       = cspmc_pkg::ST_NORMAL;
					s_next.rst_hold = 1'b0;
				end
			end
			cspmc_pkg::ST_NORMAL: begin
				if (s_reg.sleep_request || s_reg.high_osc_stop) begin
					s_next.st = cspmc_pkg::ST_SLEEP;
				end else if (s_reg.green_request) begin
					s_next.st = cspmc_pkg::ST_GREEN;
				end else if (s_reg.low_clock_select) begin
					s_next.st = cspmc_pkg::ST_SLOW;
				end
			end
			cspmc_pkg::ST_SLOW: begin
				if (s_reg.sleep_request) begin
					s_next.st = cspmc_pkg::ST_SLEEP;
				end else if (s_reg.green_request) begin
					s_next.st = cspmc_pkg::ST_GREEN;
				end else if (!s_reg.low_clock_select) begin
					s_next.st = cspmc_pkg::ST_NORMAL;
				end
			end
			cspmc_pkg::ST_GREEN: begin
				if (port_wake || wake_timer_overflow || s_reg.rtc_pulse) begin
					s_next.green_request = 1'b0;
					if (s_reg.low_clock_select) begin
						s_next.st = cspmc_pkg::ST_SLOW;
					end else begin
						s_next.st = cspmc_pkg::ST_NORMAL;
					end
				end
			end
			cspmc_pkg::ST_SLEEP: begin
				if (port_wake) begin
					s_next.st            = cspmc_pkg::ST_WARMUP;
					s_next.high_osc_stop = 1'b0;
					tmr_start            = 1'b1;
					tmr_load             = cspmc_pkg::WARMUP_CYC;
				end
			end
			cspmc_pkg::ST_WARMUP: begin
				if (tmr_done) begin
					s_next.st               = cspmc_pkg::ST_NORMAL;
					s_next.sleep_request    = 1'b0;
					s_next.low_clock_select = 1'b0;
				end
			end
			default: begin
				s_next.st = cspmc_pkg::ST_NORMAL;
			end
		endcase

		// RTC half-second period from the synchronized crystal tick
		if (s_reg.osc.rtc_xtal_en && rtc_s && !s_reg.rtc_prev) begin
			if (s_reg.rtc_cnt == cspmc_pkg::RTC_LAST) begin
				s_next.rtc_cnt   = '0;
				s_next.rtc_pulse = 1'b1;
			end else begin
				s_next.rtc_cnt = s_reg.rtc_cnt + 14'h0001;
			end
		end

		// APB: pready rises one cycle into the access phase; read data lands with it, writes one cycle later
		s_next.pready  = access && !s_reg.pready;
		s_next.pslverr = access && !s_reg.pready && (sel == 3'h0);
		if (access && !s_reg.pready) begin
			case (sel)
				3'h1: s_next.prdata = {27'h0, s_reg.green_request, s_reg.sleep_request,
					s_reg.low_clock_select, s_reg.high_osc_stop, 1'b0};
				3'h3: s_next.prdata = {30'h0, s_reg.cfg_455k, s_reg.wdt_en};
				3'h4: s_next.prdata = {26'h0, s_reg.opt, s_reg.st};
				default: s_next.prdata = 32'h0000_0000;
			endcase
		end
		// Software writes follow hardware updates, so a set in the same cycle wins
		if (access && s_reg.pready && pwrite) begin
			case (sel)
				3'h1: begin
					s_next.high_osc_stop    = pwdata[cspmc_pkg::HOS_BIT];
					s_next.low_clock_select = pwdata[cspmc_pkg::LCS_BIT];
					case (pwdata[cspmc_pkg::MODE_LSB +: 2])
						cspmc_pkg::MODE_NORMAL: begin
							s_next.sleep_request = 1'b0;
							s_next.green_request = 1'b0;
						end
						cspmc_pkg::MODE_SLEEP: begin
							s_next.sleep_request = 1'b1;
							s_next.green_request = 1'b0;
						end
						cspmc_pkg::MODE_GREEN: begin
							s_next.sleep_request = 1'b0;
							s_next.green_request = 1'b1;
						end
						default: begin
							s_next.sleep_request = s_reg.sleep_request;
						end
					endcase
				end
				3'h2: s_next.second_port_wake_enable = pwdata[7:0];
				3'h3: begin
					s_next.wdt_en   = pwdata[cspmc_pkg::WDT_EN_BIT];
					s_next.cfg_455k = pwdata[cspmc_pkg::CFG_455K_BIT];
				end
				default: begin
					s_next.wdt_en = s_reg.wdt_en;
				end
			endcase
		end

		s_next.osc = osc_of(s_next);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg                         <= '0;
			s_reg.st                      <= cspmc_pkg::ST_RST_LATCH;
			s_reg.opt                     <= cspmc_pkg::OPT_FAST_RC;
			s_reg.second_port_wake_enable <= cspmc_pkg::WAKE_EN_RESET;
			s_reg.wdt_en                  <= cspmc_pkg::WDT_EN_RESET;
			s_reg.rst_hold                <= 1'b1;
			s_reg.osc.fast_rc_en          <= 1'b1;
			s_reg.osc.slow_rc_en          <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign prdata          = s_reg.prdata;
	assign pready          = s_reg.pready;
	assign pslverr         = s_reg.pslverr;
	assign osc_ctrl        = s_reg.osc;
	assign core_reset_hold = s_reg.rst_hold;
	assign rtc_half_second = s_reg.rtc_pulse;

endmodule

// ===== hw/cspmc_pkg.sv
package cspmc_pkg;

	// ==========================================================
	// Register indices and byte addresses
	localparam logic [7:0]  OSC_MODE_IDX   = 8'hCA;
	localparam logic [7:0]  WAKE_EN_IDX    = 8'hC0;
	localparam logic [7:0]  CFG_IDX        = 8'hD0;
	localparam logic [7:0]  STATUS_IDX     = 8'hD1;
	localparam logic [11:0] OSC_MODE_ADDR  = {2'h0, OSC_MODE_IDX, 2'h0};
	localparam logic [11:0] WAKE_EN_ADDR   = {2'h0, WAKE_EN_IDX, 2'h0};
	localparam logic [11:0] CFG_ADDR       = {2'h0, CFG_IDX, 2'h0};
	localparam logic [11:0] STATUS_ADDR    = {2'h0, STATUS_IDX, 2'h0};

	// ==========================================================
	// Field positions and reset values
	localparam int          HOS_BIT        = 1;
	localparam int          LCS_BIT        = 2;
	localparam int          MODE_LSB       = 3;
	localparam int          WDT_EN_BIT     = 0;
	localparam int          CFG_455K_BIT   = 1;
	localparam logic [1:0]  MODE_NORMAL    = 2'h0;
	localparam logic [1:0]  MODE_SLEEP     = 2'h1;
	localparam logic [1:0]  MODE_GREEN     = 2'h2;
	localparam logic [7:0]  WAKE_EN_RESET  = 8'h00;
	localparam logic        WDT_EN_RESET   = 1'b1;

	// ==========================================================
	// Cycle counts
	localparam int          TMR_W          = 16;
	localparam logic [15:0] WARMUP_CYC     = 16'h0800;
	localparam logic [15:0] RST_CYC_RC     = 16'h0100;
	localparam logic [15:0] RST_CYC_XTAL   = 16'h1000;
	localparam int          RTC_XTAL_HZ    = 32768;
	localparam int          RTC_PERIOD_DIV = 2;
	localparam logic [13:0] RTC_LAST       = 14'(RTC_XTAL_HZ / RTC_PERIOD_DIV - 1);

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		OPT_FAST_RC     = 3'b000,
		OPT_FAST_RC_RTC = 3'b001,
		OPT_EXT_RC      = 3'b010,
		OPT_XTAL_32K    = 3'b011,
		OPT_XTAL_4M     = 3'b100,
		OPT_XTAL_8M     = 3'b101
	} cspmc_opt_t;

	typedef enum logic [2:0] {
		ST_RST_LATCH = 3'b000,
		ST_RST_WAIT  = 3'b001,
		ST_NORMAL    = 3'b010,
		ST_SLOW      = 3'b011,
		ST_GREEN     = 3'b100,
		ST_SLEEP     = 3'b101,
		ST_WARMUP    = 3'b110
	} cspmc_state_t;

	typedef struct packed {
		logic fast_rc_en;
		logic slow_rc_en;
		logic ext_osc_en;
		logic rtc_xtal_en;
		logic osc_in_gpio;
		logic osc_out_gpio;
		logic sys_clk_slow;
		logic cpu_run;
	} cspmc_osc_t;

endpackage

// ===== hw/cspmc_sync.sv
`timescale 1ns/10ps
module cspmc_sync #(
	parameter int W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cspmc_sync_st_t;

	cspmc_sync_st_t s_reg;
	cspmc_sync_st_t s_next;

	always_comb begin
		s_next    = s_reg;
		s_next.s1 = d;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.s2;

endmodule

// ===== hw/cspmc_delay.sv
`timescale 1ns/10ps
module cspmc_delay #(
	parameter int W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
		logic         done;
	} cspmc_delay_st_t;

	cspmc_delay_st_t s_reg;
	cspmc_delay_st_t s_next;

	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		if (start) begin
			s_next.cnt  = load;
			s_next.busy = 1'b1;
		end else if (s_reg.busy) begin
			if (s_reg.cnt <= W'(1)) begin
				s_next.cnt  = '0;
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign done = s_reg.done;

endmodule

// ===== dv/cspmc_top_sva.sv
`timescale 1ns/10ps
module cspmc_top_sva #(
	parameter logic [15:0] RST_CYC_XTAL = 16'h1000,
	parameter logic [15:0] RST_CYC_RC   = 16'h0100
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  ce,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic [2:0]            clock_option,
	input wire cspmc_pkg::cspmc_osc_t osc_ctrl,
	input wire logic                  core_reset_hold,
	input wire logic                  rtc_half_second
);
	// ==========================================================
	// Helper logic
	logic [15:0] hold_cnt;
	logic [15:0] warm_cnt;
	logic [15:0] hold_lim;
	logic        was_sleep;
	logic        asleep;

	assign asleep   = !osc_ctrl.cpu_run && !osc_ctrl.slow_rc_en && !osc_ctrl.fast_rc_en
		&& !osc_ctrl.ext_osc_en;
	assign hold_lim = (clock_option >= 3'h3) ? RST_CYC_XTAL : RST_CYC_RC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt  <= 16'h0000;
			warm_cnt  <= 16'h0000;
			was_sleep <= 1'b0;
		end else if (ce) begin
			hold_cnt  <= hold_cnt + {15'h0000, core_reset_hold};
			was_sleep <= asleep || (was_sleep && !osc_ctrl.cpu_run);
			warm_cnt  <= (was_sleep && !asleep) ? warm_cnt + 16'h0001 : 16'h0000;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	chk_apb_answer: assert property (psel && penable && !pready |=> s_answer)
		else $error("access not answered in one cycle");
	chk_pin_use: assert property (!core_reset_hold |->
		{osc_ctrl.osc_in_gpio, osc_ctrl.osc_out_gpio} ==
		{clock_option == 3'h0, clock_option == 3'h0 || clock_option == 3'h2})
		else $error("pin use does not match clock option");
	chk_rtc_option: assert property (osc_ctrl.rtc_xtal_en |-> clock_option == 3'h1)
		else $error("crystal enabled under wrong option");
	chk_rtc_pulse: assert property (rtc_half_second |-> osc_ctrl.rtc_xtal_en ##1 !rtc_half_second)
		else $error("half second pulse malformed");
	chk_reset_len: assert property ($fell(core_reset_hold) |->
		hold_cnt >= hold_lim && hold_cnt <= hold_lim + 16'h0008)
		else $error("reset stretch length wrong");
	chk_reset_normal: assert property ($fell(core_reset_hold) |->
		##[1:4] (osc_ctrl.cpu_run && !osc_ctrl.sys_clk_slow))
		else $error("no normal mode after reset");
	chk_lrc_running: assert property (osc_ctrl.cpu_run |-> osc_ctrl.slow_rc_en)
		else $error("slow RC stopped while running");
	chk_warmup_len: assert property ($rose(osc_ctrl.cpu_run) && was_sleep |->
		warm_cnt >= 16'h0800 && !osc_ctrl.sys_clk_slow)
		else $error("wake from sleep too early or not normal");
	chk_warmup_end: assert property (was_sleep && !asleep |-> warm_cnt < 16'h0834)
		else $error("wake from sleep too slow");
endmodule

bind cspmc_top cspmc_top_sva #(.RST_CYC_XTAL(RST_CYC_XTAL), .RST_CYC_RC(RST_CYC_RC))
	u_cspmc_top_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pready(pready), .clock_option(clock_option), .osc_ctrl(osc_ctrl),
	.core_reset_hold(core_reset_hold), .rtc_half_second(rtc_half_second));

// ===== dv/cspmc_osc_model.sv
`timescale 1ns/10ps
module cspmc_osc_model (
	input  wire logic                  pclk,
	input  wire cspmc_pkg::cspmc_osc_t osc_ctrl,
	input  wire logic [15:0]           flip,
	input  wire logic                  timer_fire,
	output logic      [7:0]            first_wake_port,
	output logic      [7:0]            second_wake_port,
	output logic                       wake_timer_overflow,
	output logic                       rtc_crystal_tick
);
	initial begin
		first_wake_port     = 8'h00;
		second_wake_port    = 8'h00;
		wake_timer_overflow = 1'b0;
	end
	// Pins hold their level; a flip bit toggles one pin
	always @(posedge pclk) begin
		{second_wake_port, first_wake_port} <= {second_wake_port, first_wake_port} ^ flip;
		wake_timer_overflow <= timer_fire;
	end
	// Crystal swings only while enabled, else rests low
	always begin
		rtc_crystal_tick = 1'b0;
		wait (osc_ctrl.rtc_xtal_en === 1'b1);
		#11 rtc_crystal_tick = 1'b1;
		#11;
	end
endmodule

// ===== dv/test_cspmc_top.sv
`timescale 1ns/10ps
module test_cspmc_top;
	logic                  pclk;
	logic                  presetn;
	logic                  ce;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [11:0]           paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic [2:0]            clock_option;
	logic [15:0]           flip;
	logic                  timer_fire;
	logic [7:0]            port0;
	logic [7:0]            port1;
	logic                  overflow;
	logic                  tick;
	cspmc_pkg::cspmc_osc_t osc_ctrl;
	logic                  core_reset_hold;
	logic                  rtc_half_second;
	logic [6:0]            rows [6];
	logic [31:0]           q;
	logic                  e;
	int                    n;
	time                   t0;
	int                    n_errors;
	int                    n_compared;

	cspmc_top #(.RST_CYC_XTAL(16'h0010), .RST_CYC_RC(16'h0004)) u_cspmc_top (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_option(clock_option), .first_wake_port(port0),
		.second_wake_port(port1), .wake_timer_overflow(overflow), .rtc_crystal_tick(tick),
		.osc_ctrl(osc_ctrl), .core_reset_hold(core_reset_hold),
		.rtc_half_second(rtc_half_second));

	cspmc_osc_model u_cspmc_osc_model (
		.pclk(pclk), .osc_ctrl(osc_ctrl), .flip(flip), .timer_fire(timer_fire),
		.first_wake_port(port0), .second_wake_port(port1), .wake_timer_overflow(overflow),
		.rtc_crystal_tick(tick));

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// ==========================================================
	// Tasks
	task automatic print_verdict;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED %0t no pready", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(q, x);
	endtask

	task automatic mode(input logic [2:0] s);
		rd(cspmc_pkg::STATUS_ADDR, {26'h0, 3'h1, s});
	endtask

	task automatic do_reset(input logic [2:0] opt);
		presetn <= 1'b0;
		clock_option <= opt;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic hit(input logic [15:0] f, input logic t);
		flip <= f;
		timer_fire <= t;
		@(posedge pclk);
		flip <= 16'h0;
		timer_fire <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	task automatic wait_cpu;
		n = 0;
		while (osc_ctrl.cpu_run !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
	endtask

	task automatic wait_rtc;
		n = 0;
		while (rtc_half_second !== 1'b1 && n < 40000) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		clock_option = 3'h0;
		flip = 16'h0;
		timer_fire = 1'b0;
		n_errors = 0;
		n_compared = 0;
		// Option, external osc on, input pin free, output pin free, crystal start-up
		rows = '{7'h06, 7'h10, 7'h2A, 7'h39, 7'h49, 7'h59};
		@(posedge pclk);
		foreach (rows[i]) begin
			do_reset(rows[i][6:4]);
			wait_cpu;
			check({31'h0, n >= (rows[i][0] ? 16 : 4) && n <= (rows[i][0] ? 26 : 14)}, 32'h1);
			check({30'h0, osc_ctrl.osc_in_gpio, osc_ctrl.osc_out_gpio}, {30'h0, rows[i][2:1]});
			check({31'h0, osc_ctrl.ext_osc_en}, {31'h0, rows[i][3]});
			rd(cspmc_pkg::STATUS_ADDR, {26'h0, rows[i][6:4], 3'h2});
		end
		do_reset(3'h1);
		wait_rtc;
		t0 = $time;
		@(posedge pclk);
		wait_rtc;
		check({31'h0, $time - t0 > 360420 && $time - t0 < 360480}, 32'h1);
		rd(cspmc_pkg::OSC_MODE_ADDR, 32'h0);
		rd(cspmc_pkg::CFG_ADDR, 32'h1);
		apb(1'b1, cspmc_pkg::WAKE_EN_ADDR, 32'h2);
		rd(cspmc_pkg::WAKE_EN_ADDR, 32'h0);
		rd(12'h004, 32'h0);
		check({31'h0, e}, 32'h1);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h4);
		mode(3'h3);
		check({31'h0, osc_ctrl.fast_rc_en & osc_ctrl.sys_clk_slow}, 32'h1);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h6);
		mode(3'h3);
		check({30'h0, osc_ctrl.fast_rc_en, osc_ctrl.rtc_xtal_en}, 32'h0);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h14);
		mode(3'h4);
		hit(16'h0, 1'b1);
		mode(3'h3);
		rd(cspmc_pkg::OSC_MODE_ADDR, 32'h4);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h1C);
		mode(3'h3);
		rd(cspmc_pkg::OSC_MODE_ADDR, 32'h4);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h0);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h10);
		mode(3'h4);
		hit(16'h0080, 1'b0);
		mode(3'h2);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h4);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'hC);
		@(posedge pclk);
		check({24'h0, osc_ctrl}, 32'h0);
		hit(16'h0100, 1'b1);
		check({31'h0, osc_ctrl.cpu_run}, 32'h0);
		hit(16'h0200, 1'b0);
		// Clock enable low freezes the warm-up, so the count seen after it is unchanged
		ce <= 1'b0;
		repeat (100) @(posedge pclk);
		ce <= 1'b1;
		wait_cpu;
		check({31'h0, n + 7 >= 2048 && n + 7 <= 2075}, 32'h1);
		mode(3'h2);
		rd(cspmc_pkg::OSC_MODE_ADDR, 32'h0);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h2);
		@(posedge pclk);
		check({30'h0, osc_ctrl.cpu_run, osc_ctrl.fast_rc_en}, 32'h0);
		hit(16'h0001, 1'b0);
		wait_cpu;
		mode(3'h2);
		// Green with 455K config and watchdog off stops the slow RC
		apb(1'b1, cspmc_pkg::CFG_ADDR, 32'h2);
		apb(1'b1, cspmc_pkg::OSC_MODE_ADDR, 32'h10);
		mode(3'h4);
		check({30'h0, osc_ctrl.slow_rc_en, osc_ctrl.fast_rc_en}, 32'h1);
		hit(16'h0002, 1'b0);
		mode(3'h2);
		print_verdict;
	end

	initial begin
		repeat (95000) @(posedge pclk);
		n_errors++;
		print_verdict;
	end
endmodule
